// >>> hdl/timer_output_compare.sv
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "timer_compare_defs.svh"
module timer_output_compare
  import timer_compare_pkg::*;
(
  // register bus side
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // counter section side
  input wire logic timer_tick,
  input wire logic [15:0] counter_value,
  input wire logic overflow_flag,
  // cpu core side: mask and low-power modes
  input wire logic cpu_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  output logic [1:0] tick_select,
  output logic status_read_pulse,
  output logic timer_irq,
  output logic wake_request,
  // compare pins and their drive enables
  output logic compare_pin_ch1,
  output logic compare_pin_ch2,
  output logic compare_pin_oe_ch1,
  output logic compare_pin_oe_ch2
);
  logic [7:0] compare_control; // level, force and irq enable bits
  logic [7:0] pin_control; // pin enables and tick select
  logic access_go; // bus request taken this cycle
  logic write_go; // bus write taken this cycle
  logic ack; // ack from the bus slave
  logic [7:0] write_byte; // byte lane 0 of the write data
  logic [7:0] timer_status; // assembled status byte
  logic [7:0] next_read; // read data for the taken request
  logic hit_status; // status register addressed
  logic [15:0] value_ch1; // compare value, channel one
  logic [15:0] value_ch2; // compare value, channel two
  logic flag_ch1; // match flag, channel one
  logic flag_ch2; // match flag, channel two
  logic event_ch1; // match this cycle, channel one
  logic event_ch2; // match this cycle, channel two
  logic status_read; // status read taken
  logic div2_mode; // tick is cpu clock over two
  logic irq_cause; // any enabled event pending
  logic next_pin_ch1; // pin latch next value, channel one
  logic next_pin_ch2; // pin latch next value, channel two
  logic reg_write; // write allowed to land (not halted)
  logic reg_access; // access allowed to act (not halted)
  logic sel_control; // compare_control addressed
  logic sel_pin_control; // pin_control addressed
  logic sel_high_ch1; // high byte addressed, channel one
  logic sel_low_ch1; // low byte addressed, channel one
  logic sel_high_ch2; // high byte addressed, channel two
  logic sel_low_ch2; // low byte addressed, channel two
  logic write_high_ch1; // high byte write strobe, channel one
  logic write_low_ch1; // low byte write strobe, channel one
  logic access_low_ch1; // low byte read or write, channel one
  logic write_high_ch2; // high byte write strobe, channel two
  logic write_low_ch2; // low byte write strobe, channel two
  logic access_low_ch2; // low byte read or write, channel two

  assign write_byte = wb_dat_i[7:0];
  assign hit_status = (wb_adr_i == `OFS_TIMER_STATUS);
  assign status_read = access_go && !wb_we_i && hit_status && !halt_mode;
  assign div2_mode = (tick_select_t'(pin_control[`BIT_TICK_SELECT +: 2]) == tick_div2);

  // halt freezes every software register, so no strobe may pass while it is high
  assign reg_write = write_go && !halt_mode;
  assign reg_access = access_go && !halt_mode;

  // address decode; at most one select is high, so strobes never overlap
  always_comb begin
    sel_control = 1'b0;
    sel_pin_control = 1'b0;
    sel_high_ch1 = 1'b0;
    sel_low_ch1 = 1'b0;
    sel_high_ch2 = 1'b0;
    sel_low_ch2 = 1'b0;
    if (wb_adr_i == `OFS_COMPARE_CONTROL) begin
      sel_control = 1'b1;
    end else if (wb_adr_i == `OFS_PIN_CONTROL) begin
      sel_pin_control = 1'b1;
    end else if (wb_adr_i == `OFS_COMPARE_HIGH_CH1) begin
      sel_high_ch1 = 1'b1;
    end else if (wb_adr_i == `OFS_COMPARE_LOW_CH1) begin
      sel_low_ch1 = 1'b1;
    end else if (wb_adr_i == `OFS_COMPARE_HIGH_CH2) begin
      sel_high_ch2 = 1'b1;
    end else if (wb_adr_i == `OFS_COMPARE_LOW_CH2) begin
      sel_low_ch2 = 1'b1;
    end
  end

  // per-channel strobes; a low byte read counts as an access too
  assign write_high_ch1 = reg_write && sel_high_ch1;
  assign write_low_ch1 = reg_write && sel_low_ch1;
  assign access_low_ch1 = reg_access && sel_low_ch1;
  assign write_high_ch2 = reg_write && sel_high_ch2;
  assign write_low_ch2 = reg_write && sel_low_ch2;
  assign access_low_ch2 = reg_access && sel_low_ch2;

  // bus handshake; the core decodes the address
  wb_byte_slave bus (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_ack_i_seen(ack),
    .access_go(access_go),
    .write_go(write_go)
  );

  // the ack flop is the slave's; mirror it to keep the output registered
  // a second register here would only add a cycle of latency
  assign wb_ack_o = ack;

  // channel one
  // both channels share the tick and count, so they match in step
  compare_channel ch1 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .freeze(halt_mode),
    .write_high(write_high_ch1),
    .write_low(write_low_ch1),
    .access_low(access_low_ch1),
    .status_read(status_read),
    .write_byte(write_byte),
    .tick(timer_tick),
    .counter_value(counter_value),
    .div2_mode(div2_mode),
    .compare_value(value_ch1),
    .match_flag(flag_ch1),
    .match_event(event_ch1)
  );

  // channel two
  // the status read arms each channel whose flag is set; each clears on its own low byte
  compare_channel ch2 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .freeze(halt_mode),
    .write_high(write_high_ch2),
    .write_low(write_low_ch2),
    .access_low(access_low_ch2),
    .status_read(status_read),
    .write_byte(write_byte),
    .tick(timer_tick),
    .counter_value(counter_value),
    .div2_mode(div2_mode),
    .compare_value(value_ch2),
    .match_flag(flag_ch2),
    .match_event(event_ch2)
  );

  // status byte; unused bits stay zero
  // the overflow flag lives outside this block and is only mirrored
  always_comb begin
    timer_status = 8'h00;
    timer_status[`BIT_MATCH_FLAG_CH1] = flag_ch1;
    timer_status[`BIT_OVERFLOW_FLAG] = overflow_flag;
    timer_status[`BIT_MATCH_FLAG_CH2] = flag_ch2;
  end

  // compare_control: reserved bits 7 and 1 are never stored
  // force bits are software-only; hardware never clears them
  // a write during halt is dropped, not queued
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      compare_control <= `COMPARE_CONTROL_RESET;
    end else if (reg_write && sel_control) begin
      compare_control <= write_byte & `COMPARE_CONTROL_MASK;
    end
  end

  // pin enables and tick select share one register of their own
  // its reserved bits are masked off so they always read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_control <= `PIN_CONTROL_RESET;
    end else if (reg_write && sel_pin_control) begin
      pin_control <= write_byte & `PIN_CONTROL_MASK;
    end
  end

  // tick select goes to the prescaler; 11 is passed as written
  // the copy costs a cycle but keeps the output straight from a flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tick_select <= 2'b00;
    end else begin
      tick_select <= pin_control[`BIT_TICK_SELECT +: 2];
    end
  end

  // status read pulse lets the overflow logic arm its own clear
  // no pulse in halt, so a frozen status read arms nothing
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_read_pulse <= 1'b0;
    end else begin
      status_read_pulse <= status_read;
    end
  end

  // read mux; unmapped addresses read zero and still get an ack
  // answering every address keeps a stray read from hanging the bus
  always_comb begin
    next_read = 8'h00;
    if (wb_adr_i == `OFS_COMPARE_CONTROL) begin
      next_read = compare_control;
    end else if (hit_status) begin
      next_read = timer_status;
    end else if (wb_adr_i == `OFS_COMPARE_HIGH_CH1) begin
      next_read = value_ch1[15:8];
    end else if (wb_adr_i == `OFS_COMPARE_LOW_CH1) begin
      next_read = value_ch1[7:0];
    end else if (wb_adr_i == `OFS_COMPARE_HIGH_CH2) begin
      next_read = value_ch2[15:8];
    end else if (wb_adr_i == `OFS_COMPARE_LOW_CH2) begin
      next_read = value_ch2[7:0];
    end else if (wb_adr_i == `OFS_PIN_CONTROL) begin
      next_read = pin_control;
    end
  end

  // read data registered with the ack, upper bits zero
  // held until the next read so the master may take it late
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (access_go && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, next_read};
    end
  end

  // pin latch next values: match copies level, force copies level too
  // force acts every cycle it is set; a match then gives the same level
  // halt holds the latches as they are
  always_comb begin
    next_pin_ch1 = compare_pin_ch1;
    next_pin_ch2 = compare_pin_ch2;
    if (!halt_mode && pin_control[`BIT_PIN_ENABLE_CH1]) begin
      // a disabled pin never takes the level
      if (event_ch1 || compare_control[`BIT_FORCE_LEVEL_CH1]) begin
        next_pin_ch1 = compare_control[`BIT_OUT_LEVEL_CH1];
      end
    end
    if (!halt_mode && pin_control[`BIT_PIN_ENABLE_CH2]) begin
      if (event_ch2 || compare_control[`BIT_FORCE_LEVEL_CH2]) begin
        next_pin_ch2 = compare_control[`BIT_OUT_LEVEL_CH2];
      end
    end
  end

  // pin latches, forced low in reset
  // the latch keeps its level while the pin is disabled
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      compare_pin_ch1 <= 1'b0;
      compare_pin_ch2 <= 1'b0;
    end else begin
      compare_pin_ch1 <= next_pin_ch1;
      compare_pin_ch2 <= next_pin_ch2;
    end
  end

  // pin drive follows the enables; otherwise the pin is plain i/o
  // registered with the latch so level and drive move together
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      compare_pin_oe_ch1 <= 1'b0;
      compare_pin_oe_ch2 <= 1'b0;
    end else begin
      compare_pin_oe_ch1 <= pin_control[`BIT_PIN_ENABLE_CH1];
      compare_pin_oe_ch2 <= pin_control[`BIT_PIN_ENABLE_CH2];
    end
  end

  // only flags raise the line, so forcing alone never interrupts
  // a disabled pin still lets its flag interrupt
  assign irq_cause =
    (compare_control[`BIT_COMPARE_IRQ_ENABLE] && (flag_ch1 || flag_ch2)) ||
    (compare_control[`BIT_OVERFLOW_IRQ_ENABLE] && overflow_flag);

  // one shared request line gated by the cpu mask
  // the mask only gates the line; the flags keep the request pending
  // so it shows as soon as the mask clears
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= irq_cause && !cpu_irq_mask;
    end
  end

  // wake from wait only; halt ignores timer events
  // wake ignores the cpu mask, since the core decides what to serve
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= irq_cause && wait_mode && !halt_mode;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/timer_compare_defs.svh
`ifndef TIMER_COMPARE_DEFS_SVH
`define TIMER_COMPARE_DEFS_SVH
// register byte offsets on the wishbone bus (one aligned word each)
`define OFS_COMPARE_CONTROL 6'h00
`define OFS_TIMER_STATUS 6'h04
`define OFS_COMPARE_HIGH_CH1 6'h08
`define OFS_COMPARE_LOW_CH1 6'h0c
`define OFS_COMPARE_HIGH_CH2 6'h10
`define OFS_COMPARE_LOW_CH2 6'h14
`define OFS_PIN_CONTROL 6'h18
// compare_control field positions
`define BIT_OUT_LEVEL_CH1 0
`define BIT_OUT_LEVEL_CH2 2
`define BIT_FORCE_LEVEL_CH1 3
`define BIT_FORCE_LEVEL_CH2 4
`define BIT_OVERFLOW_IRQ_ENABLE 5
`define BIT_COMPARE_IRQ_ENABLE 6
`define COMPARE_CONTROL_MASK 8'h7d
// timer_status field positions
`define BIT_MATCH_FLAG_CH1 6
`define BIT_OVERFLOW_FLAG 5
`define BIT_MATCH_FLAG_CH2 3
// pin_control field positions
`define BIT_PIN_ENABLE_CH1 7
`define BIT_PIN_ENABLE_CH2 6
`define BIT_TICK_SELECT 2
`define PIN_CONTROL_MASK 8'hcc
// reset values
`define COMPARE_CONTROL_RESET 8'h00
`define PIN_CONTROL_RESET 8'h00
`define COMPARE_VALUE_RESET 16'h8000
`endif

// >>> hdl/timer_compare_pkg.sv
package timer_compare_pkg;
  // timer tick source chosen by tick_select
  typedef enum logic [1:0] {
    tick_div4 = 2'b00,
    tick_div2 = 2'b01,
    tick_div8 = 2'b10,
    tick_rsvd = 2'b11
  } tick_select_t;
  // two-step flag clear sequence
  typedef enum logic [1:0] {
    clr_idle = 2'b01,
    clr_armed = 2'b10
  } clear_state_t;
endpackage

// >>> hdl/compare_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_compare_defs.svh"
// one compare channel: value registers, inhibit, match flag, armed clear
module compare_channel
  import timer_compare_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic freeze,
  input wire logic write_high,
  input wire logic write_low,
  input wire logic access_low,
  input wire logic status_read,
  input wire logic [7:0] write_byte,
  input wire logic tick,
  input wire logic [15:0] counter_value,
  input wire logic div2_mode,
  output logic [15:0] compare_value,
  output logic match_flag,
  output logic match_event
);
  logic inhibit; // high byte written, waiting for low byte
  clear_state_t clear_state; // status read seen with flag set
  logic [15:0] target; // counter value at which the match shows
  logic hit; // match in this cycle

  // slow ticks show the match one count late
  assign target = div2_mode ? compare_value : 16'(compare_value + 16'h0001);
  assign hit = tick && !freeze && !inhibit && (counter_value == target);
  assign match_event = hit;

  // software-only value; hardware never alters it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      compare_value <= `COMPARE_VALUE_RESET;
    end else if (write_high) begin
      compare_value[15:8] <= write_byte;
    end else if (write_low) begin
      compare_value[7:0] <= write_byte;
    end
  end

  // writing the high byte blocks compares until the low byte lands
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      inhibit <= 1'b0;
    end else if (write_high) begin
      inhibit <= 1'b1;
    end else if (write_low) begin
      inhibit <= 1'b0;
    end
  end

  // clear sequence: status read while set, then low byte access
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clear_state <= clr_idle;
    end else begin
      case (clear_state)
        clr_idle: begin
          if (status_read && match_flag) begin
            clear_state <= clr_armed;
          end
        end
        clr_armed: begin
          if (access_low) begin
            clear_state <= clr_idle;
          end
        end
        default: begin
          clear_state <= clr_idle;
        end
      endcase
    end
  end

  // flag: a match in the clearing cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      match_flag <= 1'b0;
    end else if (hit) begin
      match_flag <= 1'b1;
    end else if (clear_state == clr_armed && access_low) begin
      match_flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/wb_byte_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_compare_defs.svh"
// classic wishbone handshake: one-cycle ack, strobes for the core
module wb_byte_slave (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_i_seen,
  output logic access_go,
  output logic write_go
);
  // accept when no ack is pending so each request is taken once
  assign access_go = wb_cyc_i && wb_stb_i && !wb_ack_i_seen;
  // byte lane 0 carries the register data
  assign write_go = access_go && wb_we_i && wb_sel_i[0];

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wb_ack_i_seen <= 1'b0;
    end else begin
      wb_ack_i_seen <= access_go;
    end
  end
endmodule
`default_nettype wire

// >>> dv/tick_counter_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side stand-in: prescaler tick and free-running count
module tick_counter_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] tick_select,
  input wire logic load,
  output logic timer_tick,
  output logic [15:0] counter_value
);
  logic [2:0] div; // prescaler phase
  // one-cycle tick at the selected rate; reserved code behaves as div4
  always_ff @(posedge core_clk) begin
    if (!rst_n || load) begin
      div <= 3'h0;
      timer_tick <= 1'b0;
      counter_value <= 16'h0000;
    end else begin
      div <= div + 3'h1;
      timer_tick <= (tick_select == 2'h1) ? div[0] : (tick_select == 2'h2) ? &div : &div[1:0];
      if (timer_tick) begin
        counter_value <= counter_value + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/timer_output_compare_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_compare_defs.svh"
// port-level checks: bus answer, reset, gating of interrupt and wake
module timer_output_compare_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cpu_irq_mask,
  input wire logic halt_mode,
  input wire logic [1:0] tick_select,
  input wire logic status_read_pulse,
  input wire logic timer_irq,
  input wire logic wake_request,
  input wire logic compare_pin_ch1,
  input wire logic compare_pin_ch2
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic req; // fresh request with no answer pending
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  AST_ACK_NEXT: assert property (req |=> wb_ack_o) else $error("ack missing");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper data set");
  // reset itself is the cause here, so this one is not disabled by it
  AST_RESET_PINS: assert property (disable iff (1'b0) !rst_n |=> !compare_pin_ch1 && !compare_pin_ch2 && !timer_irq) else $error("pins not low in reset");
  AST_MASK_IRQ: assert property (cpu_irq_mask |=> !timer_irq) else $error("irq despite mask");
  AST_HALT_WAKE: assert property (halt_mode |=> !wake_request) else $error("wake from halt");
  AST_TICK_SEL: assert property (req && wb_we_i && wb_adr_i == `OFS_PIN_CONTROL && wb_sel_i[0] && !halt_mode |-> ##2 tick_select == $past(wb_dat_i[3:2], 2)) else $error("tick select lost");
  AST_STATUS_PULSE: assert property (req && !wb_we_i && wb_adr_i == `OFS_TIMER_STATUS |-> ##[1:2] status_read_pulse) else $error("no status pulse");
  cover property (wb_ack_o && wb_we_i);
  cover property ($rose(timer_irq));
  cover property ($rose(compare_pin_ch2));
endmodule
`default_nettype wire

// >>> dv/timer_output_compare_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_compare_defs.svh"
module timer_output_compare_tb import timer_compare_pkg::*;;
  logic core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, timer_tick, load;
  logic overflow_flag, cpu_irq_mask, wait_mode, halt_mode, status_read_pulse;
  logic timer_irq, wake_request, compare_pin_ch1, compare_pin_ch2;
  logic compare_pin_oe_ch1, compare_pin_oe_ch2;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] counter_value;
  logic [1:0] tick_select;
  logic [7:0] rd; // last byte read
  int failures, checks;
  timer_output_compare DUT (.*);
  tick_counter_model counter (.*);
  // compare one value, count and report a mismatch
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one classic cycle; waits for ack, no assumed latency
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(rd, e);
  endtask
  // stop just after the tick edge that presents count v
  task automatic at_count(input logic [15:0] v);
    do @(posedge core_clk); while (!(timer_tick === 1'b1 && counter_value === v));
    #1;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // the whole run needs a few hundred cycles
  initial begin
    #200000;
    failures++;
    summarize();
  end
  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, overflow_flag, cpu_irq_mask} = 6'h00;
    {wait_mode, halt_mode, wb_adr_i, wb_dat_i} = 40'h0;
    wb_sel_i = 4'h1;
    load = 1'b1; // count held at zero until set-up is done
    repeat (16) @(posedge core_clk);
    check({compare_pin_ch1, compare_pin_ch2, timer_irq}, 3'h0);
    rst_n <= 1'b1;
    rchk(`OFS_COMPARE_HIGH_CH1, 8'h80);
    rchk(`OFS_COMPARE_LOW_CH2, 8'h00);
    rchk(`OFS_COMPARE_HIGH_CH2, 8'h80);
    rchk(`OFS_COMPARE_CONTROL, 8'h00);
    rchk(6'h1c, 8'h00);
    bus(1'b1, `OFS_COMPARE_CONTROL, 8'hff);
    rchk(`OFS_COMPARE_CONTROL, 8'h7d);
    // overflow interrupt, wake from wait, then mask and halt
    bus(1'b1, `OFS_COMPARE_CONTROL, 8'h20);
    overflow_flag <= 1'b1;
    wait_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    check({timer_irq, wake_request}, 2'h3);
    rchk(`OFS_TIMER_STATUS, 8'h20);
    cpu_irq_mask <= 1'b1;
    halt_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    check({timer_irq, wake_request}, 2'h0);
    bus(1'b1, `OFS_COMPARE_CONTROL, 8'h01);
    rchk(`OFS_COMPARE_CONTROL, 8'h20);
    {halt_mode, cpu_irq_mask, overflow_flag, wait_mode} <= 4'h0;
    // both channels armed; second one left inhibited by a lone high write
    bus(1'b1, `OFS_PIN_CONTROL, {4'hc, tick_div4, 2'h0});
    bus(1'b1, `OFS_COMPARE_CONTROL, 8'h45);
    bus(1'b1, `OFS_COMPARE_HIGH_CH1, 8'h00);
    bus(1'b1, `OFS_COMPARE_LOW_CH1, 8'h10);
    bus(1'b1, `OFS_COMPARE_HIGH_CH2, 8'h00);
    bus(1'b1, `OFS_COMPARE_LOW_CH2, 8'h30);
    bus(1'b1, `OFS_COMPARE_HIGH_CH2, 8'h00);
    rchk(`OFS_COMPARE_LOW_CH1, 8'h10);
    load <= 1'b0;
    at_count(16'h0010);
    check(compare_pin_ch1, 1'b0);
    at_count(16'h0011);
    check({compare_pin_ch1, compare_pin_oe_ch1}, 2'h3);
    @(posedge core_clk);
    #1;
    check(timer_irq, 1'b1);
    at_count(16'h0031);
    check(compare_pin_ch2, 1'b0);
    bus(1'b1, `OFS_COMPARE_LOW_CH2, 8'h40);
    at_count(16'h0041);
    check(compare_pin_ch2, 1'b1);
    // low access alone must not clear; status read first does
    rchk(`OFS_COMPARE_LOW_CH1, 8'h10);
    rchk(`OFS_TIMER_STATUS, 8'h48);
    rchk(`OFS_COMPARE_LOW_CH1, 8'h10);
    rchk(`OFS_TIMER_STATUS, 8'h08);
    rchk(`OFS_COMPARE_LOW_CH2, 8'h40);
    rchk(`OFS_TIMER_STATUS, 8'h00);
    check(timer_irq, 1'b0);
    // div2: match at equal count; channel two pin released
    bus(1'b1, `OFS_COMPARE_CONTROL, 8'h40);
    bus(1'b1, `OFS_PIN_CONTROL, {4'h8, tick_div2, 2'h0});
    bus(1'b1, `OFS_COMPARE_HIGH_CH1, 8'h00);
    rchk(`OFS_TIMER_STATUS, 8'h00);
    bus(1'b1, `OFS_COMPARE_LOW_CH1, 8'h60);
    bus(1'b1, `OFS_COMPARE_HIGH_CH2, 8'h00);
    bus(1'b1, `OFS_COMPARE_LOW_CH2, 8'h60);
    at_count(16'h005f);
    check(compare_pin_ch1, 1'b1);
    at_count(16'h0060);
    check({compare_pin_ch1, compare_pin_oe_ch2, compare_pin_ch2}, 3'h1);
    @(posedge core_clk);
    #1;
    check(timer_irq, 1'b1);
    rchk(`OFS_TIMER_STATUS, 8'h48);
    rchk(`OFS_COMPARE_LOW_CH1, 8'h60);
    rchk(`OFS_COMPARE_LOW_CH2, 8'h60);
    // forced level follows the level bit, no flag and no interrupt
    bus(1'b1, `OFS_PIN_CONTROL, 8'hc0);
    bus(1'b1, `OFS_COMPARE_CONTROL, 8'h50);
    repeat (2) @(posedge core_clk);
    check(compare_pin_ch2, 1'b0);
    bus(1'b1, `OFS_COMPARE_CONTROL, 8'h54);
    repeat (2) @(posedge core_clk);
    check({compare_pin_ch2, timer_irq}, 2'h2);
    rchk(`OFS_TIMER_STATUS, 8'h00);
    summarize();
  end
endmodule
bind timer_output_compare timer_output_compare_sva sva (.*);
`default_nettype wire
